/* File: sca_pkg.sv */
// constants of the smart card auxiliary control block
// assumes an apb slave port with 32-bit data, 8-bit registers in low bits
package sca_pkg;

    // register indexes; byte address is four times the index
    localparam logic [9:0] IDX_CONT = 10'h0AC;
    localparam logic [9:0] IDX_SEL = 10'h0AB;
    localparam logic [9:0] IDX_ETU_HI = 10'h0B0;
    localparam logic [9:0] IDX_ETU_LO = 10'h0B1;
    localparam logic [9:0] IDX_GT_HI = 10'h0B2;
    localparam logic [9:0] IDX_GT_LO = 10'h0B3;
    localparam logic [9:0] IDX_CTRL = 10'h0B6;
    localparam logic [9:0] IDX_WT_TOP = 10'h0B8;
    localparam logic [9:0] IDX_WT_MID = 10'h0B9;
    localparam logic [9:0] IDX_WT_LOW = 10'h0BA;
    localparam logic [9:0] IDX_IRQ_STAT = 10'h0BB;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h0BC;
    localparam logic [9:0] IDX_CARD_STAT = 10'h0BD;
    localparam logic [9:0] IDX_PMOD = 10'h0BE;

    // field positions
    localparam int CTRL_RESET_BIT = 7;
    localparam int CTRL_SENSE_BIT = 6;
    localparam int CTRL_VSEL_HI = 5;
    localparam int CTRL_VSEL_LO = 4;
    localparam int CONT_SUPPLY_BIT = 0;
    localparam int PMOD_HALVE_BIT = 0;
    localparam int PMOD_PULLUP_BIT = 3;
    localparam int SEL_PS_LO = 0;
    localparam int SEL_PS_HI = 1;
    localparam int IRQ_PRES_BIT = 0;
    localparam int IRQ_GOOD_UP_BIT = 1;
    localparam int IRQ_GOOD_DN_BIT = 2;
    localparam int STAT_PRES_BIT = 0;
    localparam int STAT_GOOD_BIT = 1;
    localparam int STAT_ON_BIT = 2;

    // reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_CONT = 8'h00;
    localparam logic [7:0] RST_SEL = 8'h08;
    localparam logic [7:0] RST_PMOD = 8'h00;
    localparam logic [7:0] RST_IRQ = 8'h00;
    localparam logic [10:0] RST_ETU = 11'h174;
    localparam logic [8:0] RST_GT = 9'h00C;
    localparam logic [23:0] RST_WT = 24'h002580;

    // one-hot phases of the bus slave
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b01,
        ST_ANS = 2'b10
    } sca_bus_st_t;

endpackage

/* File: sca_alt_div.sv */
// alternate card clock prescaler, delivers a clock enable tick
// assumes the caller gives one clock, a clock enable and a soft reset
`timescale 1ns/100ps
`default_nettype none
module sca_alt_div
    import sca_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic soft_rst,
    // control
    input wire logic [1:0] prescale,
    // tick out
    output logic tick
);

    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    logic [2:0] div_mask;
    logic tick_next;

    // mask of low counter bits that must be zero for a tick
    assign div_mask = 3'((4'h1 << prescale) - 4'h1);
    assign cnt_next = cnt_reg + 3'h1;
    assign tick_next = (cnt_reg & div_mask) == 3'h0; // R3

    // free counter, restarted by the interface reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_reg <= 3'h0;
            tick <= 1'b0;
        end
        else if (ce)
        begin
            cnt_reg <= soft_rst ? 3'h0 : cnt_next;
            tick <= tick_next;
        end
    end

    // divide by one gives a tick every enabled cycle
    property p_alt_div1;
        @(posedge pclk) disable iff (!presetn)
        (ce && prescale == 2'h0) |=> tick;
    endproperty
    a_alt_div1: assert property (p_alt_div1) // R3
        else $error("alt clock not undivided");

    // divide by eight gives one tick in eight cycles
    property p_alt_div8;
        @(posedge pclk) disable iff (!presetn)
        (ce && prescale == 2'h3) ##1 (ce && prescale == 2'h3 && tick)
        ##1 (ce && prescale == 2'h3) |=> !tick;
    endproperty
    a_alt_div8: assert property (p_alt_div8) // R3
        else $error("alt clock divide by eight ticks too often");

endmodule
`default_nettype wire

/* File: sca_aux_top.sv */
// smart card auxiliary control: card clocks, presence, soft reset, supply
// assumes an apb master on pclk and synchronous pin inputs
//
// What this block and the software using it must do
// R1 - Software keeps the iso card clock between one and five megahertz.
// R2 - The iso card clock runs at pclk, or at half of it when halving is set.
// R3 - The alternate card clock is pclk divided by 1, 2, 4 or 8.
// R4 - Bit 3 of the power mode register disconnects the presence pull-up.
// R5 - A change of card presence can raise the interrupt.
// R6 - Software chooses the active level of presence detection.
// R7 - Sense clear: high input means no card; sense set: low means no card.
// R8 - The reset bit returns every interface register to its reset value.
// R9 - That reset sets the elementary time unit to 372.
// R10 - That reset sets the guard time to 12.
// R11 - That reset sets the waiting time to 9600.
// R12 - The supply voltage follows two select bits of the control register.
// R13 - The supply converter follows the enable bit of the contacts register.
// R14 - Software selects the voltage before it enables the converter.
// R15 - A supply-good flag is set while the supply is within range.
// R16 - Software switches the supply off before power-down.
`timescale 1ns/100ps
`default_nettype none
module sca_aux_top
    import sca_pkg::*;
(
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // card side pins
    input wire logic card_presence_input,
    input wire logic supply_in_range,
    output logic presence_pullup_en,
    output logic [1:0] supply_sel,
    output logic supply_on,
    output logic iso_card_clock_en,
    output logic alt_card_clock_en,
    output logic irq
);

    sca_bus_st_t st_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] cont_reg;
    logic [7:0] sel_reg;
    logic [7:0] pmod_reg;
    logic [10:0] etu_reg;
    logic [8:0] gt_reg;
    logic [23:0] wt_reg;
    logic [7:0] irq_stat_reg;
    logic [7:0] irq_mask_reg;
    logic present_reg;
    logic good_reg;
    logic [7:0] rdata;
    logic [7:0] wbyte;
    logic [9:0] idx;
    logic hit;
    logic done;
    logic wr;
    logic soft_rst;
    logic [7:0] irq_set;
    logic [7:0] irq_clr;
    logic [7:0] irq_stat_next;
    logic present_now;
    logic [7:0] card_stat;

    // true when a transfer addresses the given register index
    function automatic logic sel_is(input logic [9:0] a, input logic [9:0] r);
        sel_is = (a == r);
    endfunction

    // bus decode
    assign idx = paddr[11:2];
    assign wbyte = pwdata[7:0];
    assign done = psel && penable && (st_reg == ST_ANS);
    assign wr = done && pwrite;
    assign soft_rst = wr && sel_is(idx, IDX_CTRL)
        && wbyte[CTRL_RESET_BIT]; // R8
    assign hit = sel_is(idx, IDX_CONT) || sel_is(idx, IDX_SEL)
        || sel_is(idx, IDX_ETU_HI) || sel_is(idx, IDX_ETU_LO)
        || sel_is(idx, IDX_GT_HI) || sel_is(idx, IDX_GT_LO)
        || sel_is(idx, IDX_CTRL) || sel_is(idx, IDX_WT_TOP)
        || sel_is(idx, IDX_WT_MID) || sel_is(idx, IDX_WT_LOW)
        || sel_is(idx, IDX_IRQ_STAT) || sel_is(idx, IDX_IRQ_MASK)
        || sel_is(idx, IDX_CARD_STAT) || sel_is(idx, IDX_PMOD);

    // presence level as seen by software
    assign present_now = ctrl_reg[CTRL_SENSE_BIT] ? card_presence_input
        : !card_presence_input; // R6 R7
    assign card_stat = {5'h0, cont_reg[CONT_SUPPLY_BIT], good_reg,
        present_reg};

    // read mux; unused bits read as zero
    assign rdata =
        sel_is(idx, IDX_CONT) ? cont_reg :
        sel_is(idx, IDX_SEL) ? sel_reg :
        sel_is(idx, IDX_ETU_HI) ? {5'h0, etu_reg[10:8]} :
        sel_is(idx, IDX_ETU_LO) ? etu_reg[7:0] :
        sel_is(idx, IDX_GT_HI) ? {7'h0, gt_reg[8]} :
        sel_is(idx, IDX_GT_LO) ? gt_reg[7:0] :
        sel_is(idx, IDX_CTRL) ? ctrl_reg :
        sel_is(idx, IDX_WT_TOP) ? wt_reg[23:16] :
        sel_is(idx, IDX_WT_MID) ? wt_reg[15:8] :
        sel_is(idx, IDX_WT_LOW) ? wt_reg[7:0] :
        sel_is(idx, IDX_IRQ_STAT) ? irq_stat_reg :
        sel_is(idx, IDX_IRQ_MASK) ? irq_mask_reg :
        sel_is(idx, IDX_CARD_STAT) ? card_stat :
        sel_is(idx, IDX_PMOD) ? pmod_reg : 8'h00;

    // events; set beats the read clear in the same cycle
    assign irq_set = {5'h0,
        good_reg && !supply_in_range,
        !good_reg && supply_in_range,
        present_now != present_reg}; // R5
    // only bits actually returned to software are cleared
    assign irq_clr = (done && !pwrite && sel_is(idx, IDX_IRQ_STAT))
        ? prdata[7:0] : 8'h00;
    assign irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;

    // bus phase: one wait state, answer registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_reg <= ST_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (ce)
        begin
            unique case (st_reg)
                ST_IDLE:
                begin
                    if (psel && penable)
                    begin
                        st_reg <= ST_ANS;
                        pready <= 1'b1;
                        pslverr <= !hit;
                        prdata <= (pwrite || !hit) ? 32'h0000_0000
                            : {24'h00_0000, rdata};
                    end
                end
                ST_ANS:
                begin
                    st_reg <= ST_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
                default:
                begin
                    st_reg <= ST_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
            endcase
        end
    end

    // control and contacts; reset bit never stored, so it reads zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= RST_CTRL;
            cont_reg <= RST_CONT;
            sel_reg <= RST_SEL;
        end
        else if (ce)
        begin
            if (soft_rst)
            begin
                ctrl_reg <= RST_CTRL; // R8
                cont_reg <= RST_CONT;
                sel_reg <= RST_SEL;
            end
            else if (wr)
            begin
                if (sel_is(idx, IDX_CTRL))
                    ctrl_reg <= {1'b0, wbyte[6:0]};
                if (sel_is(idx, IDX_CONT))
                    cont_reg <= wbyte;
                if (sel_is(idx, IDX_SEL))
                    sel_reg <= wbyte;
            end
        end
    end

    // timing values for the card uart, kept here with their reset values
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            etu_reg <= RST_ETU;
            gt_reg <= RST_GT;
            wt_reg <= RST_WT;
        end
        else if (ce)
        begin
            if (soft_rst)
            begin
                etu_reg <= RST_ETU; // R9
                gt_reg <= RST_GT; // R10
                wt_reg <= RST_WT; // R11
            end
            else if (wr)
            begin
                if (sel_is(idx, IDX_ETU_HI))
                    etu_reg[10:8] <= wbyte[2:0];
                if (sel_is(idx, IDX_ETU_LO))
                    etu_reg[7:0] <= wbyte;
                if (sel_is(idx, IDX_GT_HI))
                    gt_reg[8] <= wbyte[0];
                if (sel_is(idx, IDX_GT_LO))
                    gt_reg[7:0] <= wbyte;
                if (sel_is(idx, IDX_WT_TOP))
                    wt_reg[23:16] <= wbyte;
                if (sel_is(idx, IDX_WT_MID))
                    wt_reg[15:8] <= wbyte;
                if (sel_is(idx, IDX_WT_LOW))
                    wt_reg[7:0] <= wbyte;
            end
        end
    end

    // power mode sits outside the interface, so soft reset leaves it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pmod_reg <= RST_PMOD;
        else if (ce && wr && sel_is(idx, IDX_PMOD))
            pmod_reg <= wbyte;
    end

    // interrupt status, mask and sampled card levels
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_stat_reg <= RST_IRQ;
            irq_mask_reg <= RST_IRQ;
            present_reg <= 1'b0;
            good_reg <= 1'b0;
            irq <= 1'b0;
        end
        else if (ce)
        begin
            present_reg <= present_now;
            good_reg <= supply_in_range; // R15
            irq_stat_reg <= soft_rst ? RST_IRQ : irq_stat_next;
            if (soft_rst)
                irq_mask_reg <= RST_IRQ;
            else if (wr && sel_is(idx, IDX_IRQ_MASK))
                irq_mask_reg <= wbyte;
            irq <= |(irq_stat_reg & irq_mask_reg); // R5
        end
    end

    // pin drivers, all registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            presence_pullup_en <= 1'b1;
            supply_sel <= 2'h0;
            supply_on <= 1'b0;
            iso_card_clock_en <= 1'b0;
        end
        else if (ce)
        begin
            presence_pullup_en <= !pmod_reg[PMOD_PULLUP_BIT]; // R4
            supply_sel <= ctrl_reg[CTRL_VSEL_HI:CTRL_VSEL_LO]; // R12
            supply_on <= cont_reg[CONT_SUPPLY_BIT]; // R13
            // halving alternates the enable; the gate cell makes the clock
            iso_card_clock_en <= pmod_reg[PMOD_HALVE_BIT]
                ? !iso_card_clock_en : 1'b1; // R2
        end
    end

    // alternate card clock prescaler
    sca_alt_div u_alt_div
    (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .soft_rst(soft_rst),
        .prescale(sel_reg[SEL_PS_HI:SEL_PS_LO]), // R3
        .tick(alt_card_clock_en)
    );

    property p_iso_full;
        @(posedge pclk) disable iff (!presetn)
        (ce && !pmod_reg[PMOD_HALVE_BIT]) |=> iso_card_clock_en;
    endproperty
    a_iso_full: assert property (p_iso_full) // R2
        else $error("iso clock enable missing at full rate");

    property p_iso_half;
        @(posedge pclk) disable iff (!presetn)
        (ce && pmod_reg[PMOD_HALVE_BIT] && iso_card_clock_en)
        |=> !iso_card_clock_en;
    endproperty
    a_iso_half: assert property (p_iso_half) // R2
        else $error("iso clock enable not halved");

    property p_pullup;
        @(posedge pclk) disable iff (!presetn)
        (ce && wr && sel_is(idx, IDX_PMOD) && wbyte[PMOD_PULLUP_BIT])
        ##1 ce |=> !presence_pullup_en;
    endproperty
    a_pullup: assert property (p_pullup) // R4
        else $error("pull-up still connected after disable");

    property p_pres_irq;
        @(posedge pclk) disable iff (!presetn)
        (ce && !soft_rst && present_now != present_reg) ##1
        (ce && irq_mask_reg[IRQ_PRES_BIT]) |=> irq;
    endproperty
    a_pres_irq: assert property (p_pres_irq) // R5
        else $error("presence change raised no interrupt");

    property p_sense;
        @(posedge pclk) disable iff (!presetn)
        (ce && (ctrl_reg[CTRL_SENSE_BIT] != card_presence_input))
        |=> !present_reg;
    endproperty
    a_sense: assert property (p_sense) // R6 R7
        else $error("card seen present at the no-card level");

    property p_soft_rst;
        @(posedge pclk) disable iff (!presetn)
        (ce && soft_rst) |=> (ctrl_reg == RST_CTRL && sel_reg == RST_SEL
        && cont_reg == RST_CONT && irq_mask_reg == RST_IRQ);
    endproperty
    a_soft_rst: assert property (p_soft_rst) // R8
        else $error("interface reset left a register set");

    property p_times;
        @(posedge pclk) disable iff (!presetn)
        (ce && soft_rst) |=> (etu_reg == 11'd372 && gt_reg == 9'd12
        && wt_reg == 24'd9600);
    endproperty
    a_times: assert property (p_times) // R9 R10 R11
        else $error("timing values not restored by interface reset");

    property p_supply;
        @(posedge pclk) disable iff (!presetn)
        ce ##1 ce |=> (supply_sel == $past(ctrl_reg[5:4], 1)
        && supply_on == $past(cont_reg[0], 1));
    endproperty
    a_supply: assert property (p_supply) // R12 R13
        else $error("supply pins do not follow the registers");

    property p_good;
        @(posedge pclk) disable iff (!presetn)
        (ce && supply_in_range) |=> card_stat[STAT_GOOD_BIT];
    endproperty
    a_good: assert property (p_good) // R15
        else $error("supply good flag not set");

    c_soft_rst: cover property (@(posedge pclk) disable iff (!presetn)
        ce && soft_rst);
    c_irq: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(irq));
    c_stat_read: cover property (@(posedge pclk) disable iff (!presetn)
        irq_clr != 8'h00);

endmodule
`default_nettype wire

/* File: sca_card_model.sv */
// card side model: presence switch, card pin pull and supply converter
// assumes the block samples these levels on pclk
`timescale 1ns/100ps
`default_nettype none
module sca_card_model
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // scenario controls
    input wire logic card_in,
    input wire logic closed_when_empty,
    input wire logic ext_pullup,
    input wire logic [3:0] ramp_cycles,
    // block pins
    input wire logic presence_pullup_en,
    input wire logic [1:0] supply_sel,
    input wire logic supply_on,
    output logic card_presence_input,
    output logic supply_in_range
);
    logic [3:0] ramp_reg;
    logic float_reg;
    logic sw_closed;
    logic pulled;
    // closed switch shorts the pin; an unpulled open pin wanders
    assign sw_closed = card_in ^ closed_when_empty;
    assign pulled = presence_pullup_en | ext_pullup;
    assign card_presence_input = sw_closed ? 1'b0 : (pulled ? 1'b1 : float_reg);
    // converter ramps after enable, collapses at once when off
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ramp_reg <= 4'h0;
            float_reg <= 1'b0;
            supply_in_range <= 1'b0;
        end
        else
        begin
            float_reg <= ~float_reg;
            if (!supply_on || supply_sel == 2'b00)
            begin
                ramp_reg <= 4'h0;
                supply_in_range <= 1'b0;
            end
            else if (ramp_reg < ramp_cycles)
                ramp_reg <= ramp_reg + 4'h1;
            else
                supply_in_range <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: sca_aux_top_tb_top.sv */
// self-checking bench of the smart card auxiliary control block
// assumes the card model on the pins and an apb master task here
`timescale 1ns/100ps
`default_nettype none
module sca_aux_top_tb_top
    import sca_pkg::*;
();
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic cpi, sir, pue, s_on, iso_en, alt_en, irq;
    logic card_in, cwe, ext_pu;
    logic [1:0] s_sel;
    int n_errors = 0;
    int samples_checked = 0;

    // block under test and its card side
    sca_aux_top uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .card_presence_input(cpi), .supply_in_range(sir),
        .presence_pullup_en(pue), .supply_sel(s_sel), .supply_on(s_on),
        .iso_card_clock_en(iso_en), .alt_card_clock_en(alt_en), .irq(irq));
    sca_card_model card (.pclk(pclk), .presetn(presetn), .card_in(card_in),
        .closed_when_empty(cwe), .ext_pullup(ext_pu), .ramp_cycles(4'h5),
        .presence_pullup_en(pue), .supply_sel(s_sel), .supply_on(s_on),
        .card_presence_input(cpi), .supply_in_range(sir));

    // 125 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, e);
        samples_checked++;
        if (s !== e)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    // one apb transfer; request held until pready seen at an edge
    task automatic apb(input logic w, input logic [9:0] idx,
        input logic [7:0] d, output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            n_errors++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic e;
        apb(1'b1, idx, d, r, e);
    endtask

    task automatic rdv(input logic [9:0] idx);
        logic e;
        apb(1'b0, idx, 8'h00, r, e);
    endtask

    task automatic rc(input string nm, input logic [9:0] idx,
        input logic [31:0] e);
        rdv(idx);
        chk(nm, r, e);
    endtask

    // let register-to-pin delays land, sample away from the edge
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // count clock-enable highs over n cycles
    task automatic cnt(input bit alt, input int n, output logic [31:0] k);
        settle(3);
        k = 32'h0;
        repeat (n)
        begin
            @(posedge pclk);
            #1;
            k = k + (alt ? alt_en : iso_en);
        end
    endtask

    task automatic t_defaults(input logic [31:0] pm);
        rc("control", IDX_CTRL, 32'h00);
        rc("contacts", IDX_CONT, 32'h00);
        rc("selection", IDX_SEL, 32'h08);
        rc("irq_mask", IDX_IRQ_MASK, 32'h00);
        rc("etu_hi", IDX_ETU_HI, 32'h01);
        rc("etu_lo", IDX_ETU_LO, 32'h74);
        rc("gt_hi", IDX_GT_HI, 32'h00);
        rc("gt_lo", IDX_GT_LO, 32'h0C);
        rc("wt_top", IDX_WT_TOP, 32'h00);
        rc("wt_mid", IDX_WT_MID, 32'h25);
        rc("wt_low", IDX_WT_LOW, 32'h80);
        rc("power_mode", IDX_PMOD, pm);
        $display("test defaults done");
    endtask

    task automatic t_unmapped();
        logic e;
        apb(1'b0, 10'h000, 8'h00, r, e);
        chk("unmapped_err", {31'h0, e}, 32'h1);
        chk("unmapped_data", r, 32'h0);
        $display("test unmapped done");
    endtask

    task automatic t_clocks();
        logic [31:0] k;
        wr(IDX_PMOD, 8'h00);
        cnt(1'b0, 8, k);
        chk("iso_full", k, 32'h8);
        // halved rate, still 62.5 MHz on this bench clock, above the card range of R1
        wr(IDX_PMOD, 8'h01);
        cnt(1'b0, 8, k);
        chk("iso_half", k, 32'h4);
        for (int p = 0; p < 4; p++)
        begin
            wr(IDX_SEL, 8'h08 | 8'(p));
            cnt(1'b1, 16, k);
            chk("alt_ticks", k, 32'(16 >> p));
        end
        wr(IDX_PMOD, 8'h08);
        settle(2);
        chk("pullup_off", {31'h0, pue}, 32'h0);
        wr(IDX_PMOD, 8'h00);
        settle(2);
        chk("pullup_on", {31'h0, pue}, 32'h1);
        $display("test clocks done");
    endtask

    task automatic t_presence();
        wr(IDX_IRQ_MASK, 8'h01);
        rdv(IDX_IRQ_STAT);
        settle(3);
        chk("irq_idle", {31'h0, irq}, 32'h0);
        @(posedge pclk);
        card_in <= 1'b1;
        settle(4);
        chk("irq_set", {31'h0, irq}, 32'h1);
        rdv(IDX_CARD_STAT);
        chk("present", r & 32'h1, 32'h1);
        rdv(IDX_IRQ_STAT);
        chk("pres_evt", r & 32'h1, 32'h1);
        settle(3);
        chk("irq_clr", {31'h0, irq}, 32'h0);
        // other switch style with the opposite sense: card still present
        wr(IDX_IRQ_MASK, 8'h00);
        cwe <= 1'b1;
        wr(IDX_CTRL, 8'h40);
        settle(3);
        rdv(IDX_CARD_STAT);
        chk("present_inv", r & 32'h1, 32'h1);
        card_in <= 1'b0;
        settle(4);
        chk("irq_masked", {31'h0, irq}, 32'h0);
        rdv(IDX_CARD_STAT);
        chk("absent_inv", r & 32'h1, 32'h0);
        rdv(IDX_IRQ_STAT);
        chk("pres_evt_m", r & 32'h1, 32'h1);
        $display("test presence done");
    endtask

    task automatic t_supply();
        for (int v = 0; v < 4; v++)
        begin
            wr(IDX_CTRL, 8'(v << 4));
            settle(2);
            chk("supply_sel", {30'h0, s_sel}, 32'(v));
        end
        // voltage chosen first, then the converter
        wr(IDX_CTRL, 8'h20);
        wr(IDX_IRQ_MASK, 8'h02);
        rdv(IDX_IRQ_STAT);
        wr(IDX_CONT, 8'h01);
        settle(2);
        chk("supply_on", {31'h0, s_on}, 32'h1);
        settle(10);
        chk("irq_good", {31'h0, irq}, 32'h1);
        rdv(IDX_CARD_STAT);
        chk("good_on", r & 32'h6, 32'h6);
        rdv(IDX_IRQ_STAT);
        chk("good_rose", r & 32'h2, 32'h2);
        wr(IDX_CONT, 8'h00);
        settle(4);
        chk("supply_off", {31'h0, s_on}, 32'h0);
        rdv(IDX_CARD_STAT);
        chk("good_off", r & 32'h6, 32'h0);
        rdv(IDX_IRQ_STAT);
        chk("good_fell", r & 32'h4, 32'h4);
        $display("test supply done");
    endtask

    task automatic t_soft();
        wr(IDX_ETU_LO, 8'h12);
        wr(IDX_GT_LO, 8'h20);
        wr(IDX_WT_LOW, 8'h01);
        wr(IDX_SEL, 8'h0B);
        wr(IDX_IRQ_MASK, 8'h07);
        wr(IDX_CONT, 8'h01);
        wr(IDX_PMOD, 8'h01);
        rc("etu_lo_w", IDX_ETU_LO, 32'h12);
        wr(IDX_CTRL, 8'hE0);
        t_defaults(32'h01);
        settle(2);
        chk("soft_supply", {31'h0, s_on}, 32'h0);
        $display("test soft reset done");
    endtask

    // clock enable low must hold the halved card clock enable still
    task automatic t_freeze();
        logic [31:0] k;
        @(posedge pclk);
        ce <= 1'b0;
        cnt(1'b0, 6, k);
        chk("iso_frozen", {31'h0, (k == 32'h0) || (k == 32'h6)},
            32'h1);
        @(posedge pclk);
        ce <= 1'b1;
        $display("test freeze done");
    endtask

    // main sequence
    initial
    begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        card_in = 1'b0;
        cwe = 1'b0;
        ext_pu = 1'b1;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        settle(2);
        chk("pullup_rst", {31'h0, pue}, 32'h1);
        t_defaults(32'h00);
        t_unmapped();
        t_clocks();
        t_presence();
        t_supply();
        t_soft();
        t_freeze();
        results();
    end
endmodule
`default_nettype wire
